// *** src/idb_fifo.sv ***
// Empty on purpose: the FIFO module is defined in idb_gen.sv

// *** src/idb_gen.sv ***
// Identify parameter block generator: words 0..255 into a FIFO
`timescale 1ns/100ps
`include "idb_params.svh"
// Functional notes
// - Word 0 is 848Ah in PC-card mode
// - Word 0 is 045Ah in fixed-disk mode
// - Word 51 returns 0200h
// - Words 54-56 current cylinders, heads, sectors
// - Words 57-58 capacity, low word first
// - Word 59 returns 0101h
// - Words 60-61 LBA addressable sector total
// - Word 63 0007h fixed, 0000h PC-card
// - Word 64 returns 0003h
// - Word 65 0078h fixed, zero PC-card
// - Word 66 0078h fixed, zero PC-card
// - Words 67 and 68 return 0078h
// - Word 88 UDMA 0-4 plus selected mode
// - Words 89 and 90 return zero
// - Word 160 returns A064h
// - Word 163 0012h fixed, zero PC-card
// - Word 164 001Bh, zero in PC-card
// - Words 165 to 255 return zero
// - Words 7-8 equal first invalid LBA
// - Serial text right justified, 20h padded
// - Model text left justified, 20h padded
// - Word 47 gives max multiple sectors
// - Delivered like a sector read stream
// - Word 7 high half, word 8 low
module idb_gen
  import idb_pkg::*;
#(
  parameter int SER_CHARS = 20,
  parameter int MOD_CHARS = 40,
  parameter int FW_CHARS = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,                      // Clock, 50 MHz
  input wire logic arst_n_i,                   // Async reset, active low
  input wire idb_pkg::idb_mode_t mode_i,       // Interface mode
  input wire logic start_i,                    // Begin a block, pulse
  input wire logic dma_en_i,                   // DMA capable config
  input wire logic multi_flash_i,              // More than one flash
  input wire logic [2:0] udma_sel_i,           // Selected UDMA mode
  input wire logic udma_sel_vld_i,             // Mode selection valid
  input wire logic [15:0] def_cyl_i,           // Default cylinders
  input wire logic [7:0] def_head_i,           // Default heads
  input wire logic [15:0] def_spt_i,           // Default sectors/track
  input wire logic [15:0] cur_cyl_i,           // Current cylinders
  input wire logic [15:0] cur_head_i,          // Current heads
  input wire logic [15:0] cur_spt_i,           // Current sectors/track
  input wire logic [31:0] cur_cap_i,           // Current capacity
  input wire logic [31:0] lba_total_i,         // LBA sector total
  input wire logic [8*SER_CHARS-1:0] ser_i,    // Serial, first char high
  input wire logic [7:0] ser_len_i,            // Serial chars used
  input wire logic [8*MOD_CHARS-1:0] model_i,  // Model, first char high
  input wire logic [7:0] model_len_i,          // Model chars used
  input wire logic [8*FW_CHARS-1:0] fw_i,      // Firmware revision
  output logic [15:0] data_o,                  // Word to data path
  output logic [7:0] index_o,                  // Index of data_o
  output logic valid_o,                        // Word available
  input wire logic ready_i,                    // Data path takes word
  output logic busy_o                          // Block in progress
);
  import idb_pkg::*;
  if (SER_CHARS != 20 || MOD_CHARS != 40 || FW_CHARS != 8) begin : g_bad_text
    $error("idb_gen: string widths fixed by the word layout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Text field helpers
  // Right justified: field chars after the pad are taken from the string head
  function automatic logic [7:0] rj_char(input logic [8*SER_CHARS-1:0] s,
                                         input logic [7:0] len,
                                         input int c);
    int pad;
    pad = SER_CHARS - int'(len);
    if (c < pad) rj_char = `IDB_PAD_BYTE;
    else rj_char = s[8*(SER_CHARS-1-(c-pad)) +: 8];
  endfunction

  function automatic logic [7:0] lj_char(input logic [8*MOD_CHARS-1:0] s,
                                         input logic [7:0] len,
                                         input int c);
    if (c >= int'(len)) lj_char = `IDB_PAD_BYTE;
    else lj_char = s[8*(MOD_CHARS-1-c) +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Word value table
  logic [2:0] udma_sel_r, udma_sel_nxt;
  logic [15:0] word_val;
  logic [7:0] idx_r, idx_nxt;
  logic fixed;
  int ci;
  always_comb begin
    fixed = (mode_i == IDB_MODE_FIXED);
    ci = 0;
    word_val = 16'h0000;
    unique case (idx_r) inside
      8'd0: word_val = fixed ? `IDB_CFG_FIXED : `IDB_CFG_REMOVABLE;
      8'd1: word_val = def_cyl_i;
      8'd3: word_val = {8'h00, def_head_i};
      8'd5: word_val = `IDB_W5_VAL;
      8'd6: word_val = def_spt_i;
      8'd7: word_val = lba_total_i[31:16];
      8'd8: word_val = lba_total_i[15:0];
      [8'd10:8'd19]: begin
        ci = 2 * (int'(idx_r) - 10);
        word_val = {rj_char(ser_i, ser_len_i, ci),
                    rj_char(ser_i, ser_len_i, ci + 1)};
      end
      8'd20: word_val = `IDB_W20_VAL;
      8'd21: word_val = `IDB_W21_VAL;
      8'd22: word_val = `IDB_W22_VAL;
      [8'd23:8'd26]: begin
        ci = 2 * (int'(idx_r) - 23);
        word_val = fw_i[8*(FW_CHARS-2-ci) +: 16];
      end
      [8'd27:8'd46]: begin
        ci = 2 * (int'(idx_r) - 27);
        word_val = {lj_char(model_i, model_len_i, ci),
                    lj_char(model_i, model_len_i, ci + 1)};
      end
      8'd47: word_val = `IDB_W47_BASE | (multi_flash_i ? 16'h0002 : 16'h0001);
      8'd49: word_val = (fixed && dma_en_i) ? `IDB_W49_DMA : `IDB_W49_NODMA;
      8'd51: word_val = `IDB_PIO_MODE_VAL;
      8'd53: word_val = `IDB_VALIDITY_VAL;
      8'd54: word_val = cur_cyl_i;
      8'd55: word_val = cur_head_i;
      8'd56: word_val = cur_spt_i;
      8'd57: word_val = cur_cap_i[15:0];
      8'd58: word_val = cur_cap_i[31:16];
      8'd59: word_val = `IDB_MULTI_VAL;
      8'd60: word_val = lba_total_i[15:0];
      8'd61: word_val = lba_total_i[31:16];
      8'd63: word_val = fixed ? `IDB_MDMA_FIXED : 16'h0000;
      8'd64: word_val = `IDB_ADV_PIO_VAL;
      8'd65, 8'd66: word_val = fixed ? `IDB_CYCLE_VAL : 16'h0000;
      8'd67, 8'd68: word_val = `IDB_CYCLE_VAL;
      8'd80: word_val = `IDB_ATA_VER_VAL;
      8'd88: word_val = (16'h0100 << udma_sel_r) | `IDB_UDMA_SUP;
      // words 89, 90 zero via default
      8'd160: word_val = `IDB_POWER_VAL;
      8'd163: word_val = fixed ? `IDB_ADV_IDE_VAL : 16'h0000;
      8'd164: word_val = fixed ? `IDB_ADV_PCC_VAL : 16'h0000;
      default: word_val = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer filling the FIFO
  idb_state_t st_r, st_nxt;
  logic fifo_wready, fifo_wvalid;
  logic [23:0] out_word;
  logic out_valid, out_take;
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    fifo_wvalid = 1'b0;
    udma_sel_nxt = udma_sel_vld_i ? udma_sel_i : udma_sel_r;
    unique case (st_r)
      IDB_IDLE: begin
        // Refused while the previous last word still waits
        if (start_i && !busy_o) begin
          st_nxt = IDB_FILL;
          idx_nxt = 8'h00;
        end
      end
      IDB_FILL: begin
        fifo_wvalid = 1'b1;
        if (fifo_wready) begin
          if (idx_r == `IDB_LAST_WORD) st_nxt = IDB_DONE;
          else idx_nxt = idx_r + 8'h01;
        end
      end
      IDB_DONE: begin
        if (!out_valid) st_nxt = IDB_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= IDB_IDLE;
      idx_r <= 8'h00;
      udma_sel_r <= `IDB_UDMA_DEF_SEL;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      udma_sel_r <= udma_sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO and registered output stage
  idb_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wdata_i({idx_r, word_val}),
    .wvalid_i(fifo_wvalid),
    .wready_o(fifo_wready),
    .rdata_o(out_word),
    .rvalid_o(out_valid),
    .rready_i(out_take)
  );
  logic [15:0] data_nxt;
  logic [7:0] index_nxt;
  logic valid_nxt, busy_nxt;
  // Skid-free output: refill when empty or word consumed
  always_comb begin
    out_take = !valid_o || ready_i;
    valid_nxt = out_take ? out_valid : valid_o;
    data_nxt = (out_take && out_valid) ? out_word[15:0] : data_o;
    index_nxt = (out_take && out_valid) ? out_word[23:16] : index_o;
    busy_nxt = (st_nxt != IDB_IDLE) || valid_nxt;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= 16'h0000;
      index_o <= 8'h00;
      valid_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      data_o <= data_nxt;
      index_o <= index_nxt;
      valid_o <= valid_nxt;
      busy_o <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_word0_pccard: assert property (
    valid_o && index_o == 8'd0 && mode_i == IDB_MODE_PCCARD
    |-> data_o == 16'h848a) else $error("word 0 wrong in PC-card mode");
  a_word0_fixed: assert property (
    valid_o && index_o == 8'd0 && mode_i == IDB_MODE_FIXED
    |-> data_o == 16'h045a) else $error("word 0 wrong in fixed mode");
  a_word51_const: assert property (
    valid_o && index_o == 8'd51 |-> data_o == 16'h0200)
    else $error("word 51 wrong");
  a_word59_const: assert property (
    valid_o && index_o == 8'd59 |-> data_o == 16'h0101)
    else $error("word 59 wrong");
  a_mdma_mode: assert property (
    valid_o && index_o == 8'd63
    |-> data_o == (mode_i == IDB_MODE_FIXED ? 16'h0007 : 16'h0000))
    else $error("word 63 wrong");
  a_cycle_pio: assert property (
    valid_o && (index_o == 8'd67 || index_o == 8'd68)
    |-> data_o == 16'h0078) else $error("PIO cycle word wrong");
  a_power_desc: assert property (
    valid_o && index_o == 8'd160 |-> data_o == 16'ha064)
    else $error("word 160 wrong");
  a_tail_zero: assert property (
    valid_o && index_o >= 8'd165 |-> data_o == 16'h0000)
    else $error("reserved tail not zero");
  a_hold_stall: assert property (
    valid_o && !ready_i |=> valid_o && $stable(data_o) && $stable(index_o))
    else $error("word changed under stall");
  a_index_step: assert property (
    valid_o && ready_i && index_o != 8'hff ##1 valid_o
    |-> index_o == $past(index_o) + 8'h01) else $error("index skipped");

  a_geom_cur: assert property (
    valid_o && index_o inside {8'd54, 8'd55, 8'd56}
    |-> data_o == (index_o == 8'd54 ? cur_cyl_i :
                   index_o == 8'd55 ? cur_head_i : cur_spt_i))
    else $error("current geometry word wrong");
  a_cap_halves: assert property (
    valid_o && (index_o == 8'd57 || index_o == 8'd58)
    |-> data_o == (index_o == 8'd57 ? cur_cap_i[15:0] : cur_cap_i[31:16]))
    else $error("capacity word wrong");
  a_lba_halves: assert property (
    valid_o && (index_o == 8'd60 || index_o == 8'd61)
    |-> data_o == (index_o == 8'd60 ? lba_total_i[15:0] :
                   lba_total_i[31:16]))
    else $error("LBA total word wrong");
  a_card_total: assert property (
    valid_o && (index_o == 8'd7 || index_o == 8'd8)
    |-> data_o == (index_o == 8'd7 ? lba_total_i[31:16] :
                   lba_total_i[15:0]))
    else $error("sectors per card word wrong");
  a_adv_pio: assert property (
    valid_o && index_o == 8'd64 |-> data_o == 16'h0003)
    else $error("word 64 wrong");
  a_mdma_cycle: assert property (
    valid_o && (index_o == 8'd65 || index_o == 8'd66)
    |-> data_o == (mode_i == IDB_MODE_FIXED ? 16'h0078 : 16'h0000))
    else $error("DMA cycle word wrong");
  a_udma_word: assert property (
    valid_o && index_o == 8'd88
    |-> data_o[7:0] == 8'h1f && $onehot(data_o[15:8]))
    else $error("word 88 wrong");
  a_erase_zero: assert property (
    valid_o && (index_o == 8'd89 || index_o == 8'd90)
    |-> data_o == 16'h0000) else $error("erase time word not zero");
  a_ide_timing: assert property (
    valid_o && index_o == 8'd163
    |-> data_o == (mode_i == IDB_MODE_FIXED ? 16'h0012 : 16'h0000))
    else $error("word 163 wrong");
  a_pcc_timing: assert property (
    valid_o && index_o == 8'd164
    |-> data_o == (mode_i == IDB_MODE_FIXED ? 16'h001b : 16'h0000))
    else $error("word 164 wrong");
  a_multi_count: assert property (
    valid_o && index_o == 8'd47
    |-> data_o == (multi_flash_i ? 16'h8002 : 16'h8001))
    else $error("word 47 wrong");
  a_reserved_mid: assert property (
    valid_o && index_o inside {[8'd69:8'd79], [8'd92:8'd127]}
    |-> data_o == 16'h0000) else $error("reserved word not zero");

  c_full_block: cover property (valid_o && ready_i && index_o == 8'hff);
  c_fifo_full: cover property (st_r == IDB_FILL && !fifo_wready);
  c_fixed_word0: cover property (valid_o && index_o == 8'd0 &&
                                 mode_i == IDB_MODE_FIXED);
endmodule // idb_gen

////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid/ready on both sides
module idb_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,               // Clock
  input wire logic arst_n_i,            // Async reset, active low
  input wire logic [WIDTH-1:0] wdata_i, // Write data
  input wire logic wvalid_i,            // Write valid
  output logic wready_o,                // Not full
  output logic [WIDTH-1:0] rdata_o,     // Read data
  output logic rvalid_o,                // Not empty
  input wire logic rready_i             // Read ready
);
  localparam int AW = $clog2(DEPTH);
  // Wrap-bit full test only works for a power of two
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_size
    $error("idb_fifo: DEPTH must be a power of two of 2 or more");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic do_wr, do_rd;
  always_comb begin
    do_wr = wvalid_i && wready_o;
    do_rd = rvalid_o && rready_i;
    wp_nxt = do_wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;
  end
  assign wready_o = !((wp_r[AW] != rp_r[AW]) &&
                      (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign rvalid_o = (wp_r != rp_r);
  assign rdata_o = mem_r[rp_r[AW-1:0]];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
  // Storage holds no reset; only pointers define content
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_r[wp_r[AW-1:0]] <= wdata_i;
    end
  end
endmodule // idb_fifo

// *** src/idb_params.svh ***
// Constants for the identify parameter block generator
`ifndef IDB_PARAMS_SVH
`define IDB_PARAMS_SVH
`define IDB_CFG_REMOVABLE 16'h848a
`define IDB_CFG_FIXED 16'h045a
`define IDB_W5_VAL 16'h0200
`define IDB_W20_VAL 16'h0002
`define IDB_W21_VAL 16'h0002
`define IDB_W22_VAL 16'h0004
`define IDB_W47_BASE 16'h8000
`define IDB_W49_DMA 16'h0f00
`define IDB_W49_NODMA 16'h0e00
`define IDB_PIO_MODE_VAL 16'h0200
`define IDB_VALIDITY_VAL 16'h0007
`define IDB_MULTI_VAL 16'h0101
`define IDB_MDMA_FIXED 16'h0007
`define IDB_ADV_PIO_VAL 16'h0003
`define IDB_CYCLE_VAL 16'h0078
`define IDB_ATA_VER_VAL 16'h0020
`define IDB_UDMA_SUP 16'h001f
`define IDB_UDMA_DEF_SEL 3'h4
`define IDB_POWER_VAL 16'ha064
`define IDB_ADV_IDE_VAL 16'h0012
`define IDB_ADV_PCC_VAL 16'h001b
`define IDB_PAD_BYTE 8'h20
`define IDB_LAST_WORD 8'hff
`endif

// *** src/idb_pkg.sv ***
// Types for the identify parameter block generator
package idb_pkg;
  typedef enum logic {IDB_MODE_PCCARD, IDB_MODE_FIXED} idb_mode_t;
  typedef enum logic [1:0] {IDB_IDLE, IDB_FILL, IDB_DONE} idb_state_t;
endpackage

// *** testbench/idb_host_model.sv ***
// Host-side reader model that drains identify words from the data path
`timescale 1ns/100ps
module idb_host_model (
  input wire logic clk_i,          // Clock
  input wire logic arst_n_i,       // Async reset, active low
  input wire logic [15:0] data_i,  // Word from block
  input wire logic [7:0] index_i,  // Index of word
  input wire logic valid_i,        // Word available
  input wire logic slow_i,         // Take one word in four cycles
  input wire logic hold_i,         // Stall completely
  input wire logic clr_i,          // Clear count before a block
  output logic ready_o,            // Word taken this cycle
  output logic [8:0] count_o,      // Words taken
  output logic order_err_o         // Index out of sequence
);
  logic [1:0] pace_r;
  logic [15:0] words [256];
  // Slow pace lets the block's buffer fill up behind the stall
  assign ready_o = !hold_i && (!slow_i || pace_r == 2'h0);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pace_r <= 2'h0;
      count_o <= 9'h000;
      order_err_o <= 1'b0;
    end else begin
      pace_r <= pace_r + 2'h1;
      if (clr_i) begin
        count_o <= 9'h000;
        order_err_o <= 1'b0;
      end else if (valid_i && ready_o) begin
        words[index_i] <= data_i;
        if (index_i != count_o[7:0] || count_o[8])
          order_err_o <= 1'b1;
        count_o <= count_o + 9'h001;
      end
    end
  end
endmodule // idb_host_model

// *** testbench/tb_idb_gen.sv ***
// Testbench for the identify parameter block generator
`timescale 1ns/100ps
module tb_idb_gen;
  import idb_pkg::*;
  logic clk_i, arst_n_i, start_i, udma_sel_vld_i, ready_i, busy_o, valid_o;
  logic slow, hold, clr, order_err, mf;
  idb_mode_t mode_i;
  logic [2:0] udma_sel_i, us;
  logic [15:0] data_o, cyl, hd, spt;
  logic [7:0] index_o;
  logic [8:0] count;
  logic [31:0] cap, lba;
  logic [159:0] ser;
  logic [319:0] model;
  int n_fail, samples_checked;

  idb_gen dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_i(mode_i),
    .start_i(start_i), .dma_en_i(1'b1), .multi_flash_i(mf),
    .udma_sel_i(udma_sel_i), .udma_sel_vld_i(udma_sel_vld_i),
    .def_cyl_i(cyl), .def_head_i(hd[7:0]), .def_spt_i(spt),
    .cur_cyl_i(cyl), .cur_head_i(hd), .cur_spt_i(spt), .cur_cap_i(cap),
    .lba_total_i(lba), .ser_i(ser), .ser_len_i(8'h02), .model_i(model),
    .model_len_i(8'h02), .fw_i(64'h3130_2e30_2020_2020),
    .data_o(data_o), .index_o(index_o), .valid_o(valid_o),
    .ready_i(ready_i), .busy_o(busy_o));
  idb_host_model host (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .data_i(data_o), .index_i(index_o), .valid_i(valid_o), .slow_i(slow),
    .hold_i(hold), .clr_i(clr), .ready_o(ready_i), .count_o(count),
    .order_err_o(order_err));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Checked %0d values, %0d mismatches", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask

  // Bit 16 marks a word whose value is pinned down
  function automatic logic [16:0] expw(input int i);
    logic fx;
    fx = (mode_i == IDB_MODE_FIXED);
    case (i) inside
      0: return {1'b1, fx ? 16'h045a : 16'h848a};
      7: return {1'b1, lba[31:16]};
      8: return {1'b1, lba[15:0]};
      [10:18]: return {1'b1, 16'h2020};
      19: return {1'b1, 16'h4142};
      27: return {1'b1, 16'h5859};
      [28:46]: return {1'b1, 16'h2020};
      47: return {1'b1, mf ? 16'h8002 : 16'h8001};
      51: return {1'b1, 16'h0200};
      54: return {1'b1, cyl};
      55: return {1'b1, hd};
      56: return {1'b1, spt};
      57: return {1'b1, cap[15:0]};
      58: return {1'b1, cap[31:16]};
      59: return {1'b1, 16'h0101};
      60: return {1'b1, lba[15:0]};
      61: return {1'b1, lba[31:16]};
      63: return {1'b1, fx ? 16'h0007 : 16'h0000};
      64: return {1'b1, 16'h0003};
      65, 66: return {1'b1, fx ? 16'h0078 : 16'h0000};
      67, 68: return {1'b1, 16'h0078};
      88: return {1'b1, (16'h0100 << us) | 16'h001f};
      160: return {1'b1, 16'ha064};
      163: return {1'b1, fx ? 16'h0012 : 16'h0000};
      164: return {1'b1, fx ? 16'h001b : 16'h0000};
      52, 62, [69:79], 89, 90, [92:127], [165:255]: return 17'h10000;
      default: return 17'h00000;
    endcase
  endfunction

  task automatic check_all();
    logic [16:0] e;
    for (int i = 0; i < 256; i++) begin
      e = expw(i);
      if (e[16])
        chk($sformatf("word %0d", i), e[15:0], host.words[i]);
    end
  endtask

  // Runs one block; optional full stall and a refused second start
  task automatic run_block(input bit stall, input bit restart);
    int k;
    clr <= 1'b1;
    hold <= stall;
    @(posedge clk_i);
    clr <= 1'b0;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("busy_o", 16'h0001, {15'h0, busy_o});
    if (stall) begin
      repeat (40) @(posedge clk_i);
      #1;
      chk("valid_o held", 16'h0001, {15'h0, valid_o});
      chk("index_o held", 16'h0000, {8'h0, index_o});
      @(posedge clk_i);
      hold <= 1'b0;
    end
    if (restart) begin
      repeat (20) @(posedge clk_i);
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
    end
    k = 0;
    while (busy_o !== 1'b0 && k < 5000) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k == 5000) begin
      n_fail++;
      $display("BAD busy_o expected 0 seen %b", busy_o);
      stop_test();
    end
    repeat (5) @(posedge clk_i);
    #1;
    chk("word count", 16'h0100, {7'h0, count});
    chk("index order", 16'h0000, {15'h0, order_err});
    chk("valid_o after", 16'h0000, {15'h0, valid_o});
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fixed();
    mode_i <= IDB_MODE_FIXED;
    run_block(1'b1, 1'b0);
    check_all();
    $display("test fixed_stall done");
  endtask

  task automatic t_pccard();
    mode_i <= IDB_MODE_PCCARD;
    slow <= 1'b1;
    mf <= 1'b0;
    cap <= 32'h00ab_cdef;
    lba <= 32'h0123_4567;
    run_block(1'b0, 1'b1);
    check_all();
    slow <= 1'b0;
    mf <= 1'b1;
    $display("test pccard_slow_restart done");
  endtask

  task automatic t_udma();
    mode_i <= IDB_MODE_FIXED;
    for (int s = 0; s < 5; s++) begin
      udma_sel_i <= s[2:0];
      udma_sel_vld_i <= 1'b1;
      @(posedge clk_i);
      udma_sel_vld_i <= 1'b0;
      us = s[2:0];
      run_block(1'b0, 1'b0);
      check_all();
    end
    $display("test udma_select done");
  endtask

  initial begin
    arst_n_i = 1'b0;
    start_i = 1'b0;
    mode_i = IDB_MODE_FIXED;
    udma_sel_i = 3'h0;
    udma_sel_vld_i = 1'b0;
    us = 3'h4;
    slow = 1'b0;
    mf = 1'b1;
    hold = 1'b0;
    clr = 1'b0;
    cyl = 16'h03c7;
    hd = 16'h0010;
    spt = 16'h003f;
    cap = 32'h000e_b4f0;
    lba = 32'h8765_4321;
    ser = {16'h4142, 144'h0};
    model = {16'h5859, 304'h0};
    n_fail = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1;
    chk("valid_o reset", 16'h0000, {15'h0, valid_o});
    chk("busy_o reset", 16'h0000, {15'h0, busy_o});
    $display("test reset done");
    @(posedge clk_i);
    t_fixed();
    t_pccard();
    t_udma();
    stop_test();
  end
endmodule // tb_idb_gen
